//--- rate_gen.sv
// Serial rate generator with AXI4-Lite registers and receive majority filter
//
// Design decisions made here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module rate_gen (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic sleep_mode,
    input wire rate_pkg::stat_s stat,
    input wire logic rx_pin,
    output rate_pkg::ctrl_s ctrl,
    output logic rate_tick,
    output logic rx_level
);
    import rate_pkg::*;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wd,
                                         input logic [7:0] mask);
        merge = (old & ~mask) | (wd & mask);
    endfunction

    function automatic logic [15:0] divisor(input st_s s);
        if (s.ratec[RATE_WIDE_BIT]) begin
            divisor = {s.divh, s.divl};
        end else begin
            divisor = {8'h00, s.divl};
        end
    endfunction

    function automatic logic [8:0] reg_read(input logic [7:0] a, input st_s s,
                                            input stat_s t);
        reg_read = {1'b1, 8'h00};
        case (a)
            OFS_TXSC: reg_read[7:0] = merge(s.txsc, {6'h00, t.tx_empty, 1'b0}, ~TXSC_WMASK);
            OFS_RXSC: reg_read[7:0] = merge(s.rxsc,
                {5'h00, t.rx_frame_err, t.rx_overrun, t.rx_bit9}, ~RXSC_WMASK);
            OFS_RATE: reg_read[7:0] = merge(s.ratec, {1'b0, t.rx_idle, 6'h00}, ~RATE_WMASK);
            OFS_DIVH: reg_read[7:0] = s.divh;
            OFS_DIVL: reg_read[7:0] = s.divl;
            default: reg_read = 9'h000;
        endcase
    endfunction

    st_s q;
    st_s d;
    logic div_wr;
    logic wr_any;
    logic run;
    logic sync_mode;
    logic master;
    logic wide;
    logic hs;
    logic [3:0] post_max;
    logic [15:0] n;
    logic [8:0] rd;

    // ****************************************************************
    // Mode decode
    // ****************************************************************
    assign sync_mode = q.txsc[TX_SYNC_BIT];
    assign master = q.txsc[TX_MASTER_BIT];
    assign wide = q.ratec[RATE_WIDE_BIT];
    assign hs = q.txsc[TX_HS_BIT] & ~sync_mode;
    assign n = divisor(q);
    // Sync slave takes its clock from outside, so the generator idles
    // No clock reaches the generator in sleep, but idle keeps it going
    assign run = ~sleep_mode & ~(sync_mode & ~master);

    always_comb begin
        if (!sync_mode && !wide && !hs) begin
            post_max = POST_LOW;
        end else if (!sync_mode && (wide ^ hs)) begin
            post_max = POST_MID;
        end else begin
            post_max = POST_NONE;
        end
    end

    assign rate_tick = run & (q.pre == PRE_LAST) & (q.tmr >= n) & (q.post >= post_max);

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        d = q;
        div_wr = 1'b0;
        wr_any = 1'b0;
        rd = reg_read(araddr, q, stat);
        if (awvalid && awready) begin
            d.aw_got = 1'b1;
            d.aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            d.w_got = 1'b1;
            d.w_data = wdata[7:0];
            d.w_en = wstrb[0];
        end
        if (bvalid && bready) begin
            d.bvalid = 1'b0;
        end
        if (d.aw_got && d.w_got) begin
            d.aw_got = 1'b0;
            d.w_got = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = RESP_OKAY;
            wr_any = d.w_en;
            case (d.aw_addr)
                OFS_TXSC: if (d.w_en) d.txsc = merge(q.txsc, d.w_data, TXSC_WMASK);
                OFS_RXSC: if (d.w_en) d.rxsc = merge(q.rxsc, d.w_data, RXSC_WMASK);
                OFS_RATE: if (d.w_en) d.ratec = merge(q.ratec, d.w_data, RATE_WMASK);
                OFS_DIVH: begin
                    if (d.w_en) d.divh = d.w_data;
                    div_wr = d.w_en;
                end
                OFS_DIVL: begin
                    if (d.w_en) d.divl = d.w_data;
                    div_wr = d.w_en;
                end
                default: begin
                    d.bresp = RESP_SLVERR;
                    wr_any = 1'b0;
                end
            endcase
        end
        if (rvalid && rready) begin
            d.rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            d.rvalid = 1'b1;
            d.rdata = rd[7:0];
            d.rresp = rd[8] ? RESP_OKAY : RESP_SLVERR;
        end

        // Up-count with >= compare so a shrunken divisor never runs to 65535
        if (run) begin
            d.pre = q.pre + 2'h1;
            if (q.pre == PRE_LAST) begin
                if (q.tmr >= n) begin
                    d.tmr = 16'h0000;
                    d.post = (q.post >= post_max) ? 4'h0 : q.post + 4'h1;
                end else begin
                    d.tmr = q.tmr + 16'h0001;
                end
            end
        end
        if (div_wr) begin
            d.pre = 2'h0;
            d.tmr = 16'h0000;
            d.post = 4'h0;
        end

        d.rx_s1 = rx_pin;
        d.rx_s2 = q.rx_s1;
        d.smp = {q.smp[1:0], q.rx_s2};
        d.rx_level = (q.smp[0] & q.smp[1]) | (q.smp[1] & q.smp[2]) |
                     (q.smp[0] & q.smp[2]);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= ST_RST;
        end else begin
            q <= d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign awready = ~q.aw_got & ~q.bvalid;
    assign wready = ~q.w_got & ~q.bvalid;
    assign bvalid = q.bvalid;
    assign bresp = q.bresp;
    assign arready = ~q.rvalid;
    assign rvalid = q.rvalid;
    assign rresp = q.rresp;
    assign rdata = {24'h000000, q.rdata};
    assign rx_level = q.rx_level;
    assign ctrl = '{txsc: q.txsc, rxsc: q.rxsc, ratec: q.ratec};

    // ****************************************************************
    // Assertions
    // ****************************************************************
    // Period checker: counts cycles between ticks, trusted only after a
    // tick that followed the last register write
    logic [23:0] hcnt_q;
    logic hvalid_q;
    logic [23:0] n8p1;
    logic [23:0] n16p1;

    assign n8p1 = {16'h0000, q.divl} + 24'h000001;
    assign n16p1 = {8'h00, q.divh, q.divl} + 24'h000001;

    always_ff @(posedge aclk) begin
        if (!aresetn || wr_any || rate_tick) begin
            hcnt_q <= 24'h000000;
        end else if (run) begin
            hcnt_q <= hcnt_q + 24'h000001;
        end
        if (!aresetn || wr_any) begin
            hvalid_q <= 1'b0;
        end else if (rate_tick) begin
            hvalid_q <= 1'b1;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_narrow_after_reset: assert property ($past(!aresetn) |-> !wide)
        else $error("Divider not 8-bit after reset");
    a_timer_free_run: assert property (run && !div_wr |=> q.pre == $past(q.pre) + 2'h1)
        else $error("Rate timer prescale not advancing");
    a_div_restart: assert property (div_wr |=> q.tmr == 16'h0000 && q.pre == 2'h0
        && q.post == 4'h0)
        else $error("Divisor write did not clear rate timer");
    a_async_low8: assert property (rate_tick && hvalid_q && !sync_mode && !wide
        && !q.txsc[TX_HS_BIT] |-> hcnt_q + 24'h000001 == (n8p1 << 6))
        else $error("Async 8-bit low speed period wrong");
    a_async_low16: assert property (rate_tick && hvalid_q && !sync_mode && wide
        && !q.txsc[TX_HS_BIT] |-> hcnt_q + 24'h000001 == (n16p1 << 4))
        else $error("Async 16-bit low speed period wrong");
    a_sync_narrow: assert property (rate_tick && hvalid_q && sync_mode && !wide
        |-> hcnt_q + 24'h000001 == (n8p1 << 2))
        else $error("Sync 8-bit period wrong");
    a_high_speed: assert property (rate_tick && hvalid_q && (hs || sync_mode)
        |-> hcnt_q + 24'h000001 == ((wide || sync_mode) ? (n16p1 << 2) : (n8p1 << 4))
        || (sync_mode && !wide))
        else $error("High speed or 16-bit sync period wrong");
    a_slave_quiet: assert property (sync_mode && !master |-> !rate_tick)
        else $error("Tick produced in sync slave mode");
    a_sleep_freeze: assert property (sleep_mode && !div_wr |=> $stable(q.tmr)
        && $stable(q.pre))
        else $error("Rate timer moved during sleep");
    a_majority_high: assert property (q.smp == 3'h3 || q.smp == 3'h6
        |=> q.rx_level)
        else $error("Majority filter missed a high level");
    a_majority_low: assert property (q.smp == 3'h1 || q.smp == 3'h4
        |=> !q.rx_level)
        else $error("Majority filter missed a low level");
    a_resp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("Write response dropped before accepted");

    // ****************************************************************
    // Handshake, tick and filter checks
    // ****************************************************************
    // Bus checks cover the slave side only; master misuse is not flagged
    a_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata)
        && $stable(rresp))
        else $error("Read response dropped or changed before accepted");
    a_write_answer: assert property (awvalid && awready && wvalid && wready |=> bvalid)
        else $error("No write response after address and data taken");
    a_read_answer: assert property (arvalid && arready |=> rvalid)
        else $error("No read response after address taken");
    a_write_refuse: assert property (bvalid |-> !awready && !wready)
        else $error("Write channels ready while response pending");
    a_read_refuse: assert property (rvalid |-> !arready)
        else $error("Read address ready while read data pending");
    a_read_upper: assert property (rvalid |-> rdata[31:8] == 24'h000000)
        else $error("Read data upper lanes not zero");
    a_tick_pulse: assert property (rate_tick |=> !rate_tick)
        else $error("Rate tick wider than one cycle");
    a_sleep_quiet: assert property (sleep_mode |-> !rate_tick)
        else $error("Tick produced during sleep");
    // Filter starts at the idle high level so no false start bit follows reset
    a_level_reset: assert property ($past(!aresetn) |-> q.rx_level)
        else $error("Receive level not idle high after reset");
    a_majority_one: assert property (q.smp == 3'h5 || q.smp == 3'h7
        |=> q.rx_level)
        else $error("Majority filter missed a high level");
    a_majority_zero: assert property (q.smp == 3'h0 || q.smp == 3'h2
        |=> !q.rx_level)
        else $error("Majority filter missed a low level");

    c_async_low: cover property (rate_tick && hvalid_q && !sync_mode && !wide && !hs);
    c_async_wide: cover property (rate_tick && hvalid_q && !sync_mode && wide);
    c_sync_master: cover property (rate_tick && sync_mode && master);
    c_div_restart: cover property (div_wr && q.tmr != 16'h0000);
    c_sleep_hold: cover property (sleep_mode && q.tmr != 16'h0000);

endmodule
`default_nettype wire

//--- rate_pkg.sv
// Constants and types for the serial rate generator
//
// Overview of operation
// - Divider is 8-bit after reset, 16-bit when wide divider select set
// - Free-running timer period set by the divisor register pair
// - Sync mode ignores high speed select; async uses it and wide select
// - In sync mode rates apply only as clock master; sync slave takes external clock
// - Any divisor write clears the rate timer at once
// - Async, 8-bit, low speed: rate is clock over 64 times (n + 1)
// - Async, 16-bit, low speed: rate is clock over 16 times (n + 1)
// - Sync, 8-bit: rate is clock over 4 times (n + 1), any speed
// - Divisor n is high byte concatenated with low byte
// - Generator stops in sleep, keeps running in primary idle
// - Receive level is majority of three samples of the pin
// - With wide select clear only the low byte is used
// - Sync mode select set means synchronous, clear means asynchronous
package rate_pkg;

    // ****************************************************************
    // Register map and fields
    // ****************************************************************
    localparam logic [7:0] OFS_TXSC = 8'h00;
    localparam logic [7:0] OFS_RXSC = 8'h04;
    localparam logic [7:0] OFS_RATE = 8'h08;
    localparam logic [7:0] OFS_DIVH = 8'h0C;
    localparam logic [7:0] OFS_DIVL = 8'h10;
    localparam int TX_MASTER_BIT = 7;
    localparam int TX_SYNC_BIT = 4;
    localparam int TX_HS_BIT = 2;
    localparam int TX_EMPTY_BIT = 1;
    localparam int RX_FERR_BIT = 2;
    localparam int RX_OERR_BIT = 1;
    localparam int RATE_IDLE_BIT = 6;
    localparam int RATE_WIDE_BIT = 3;
    localparam logic [7:0] TXSC_WMASK = 8'hFD;
    localparam logic [7:0] RXSC_WMASK = 8'hF8;
    localparam logic [7:0] RATE_WMASK = 8'h1B;
    localparam logic [7:0] TXSC_RST = 8'h00;
    localparam logic [7:0] RXSC_RST = 8'h00;
    localparam logic [7:0] RATE_RST = 8'h10;
    localparam logic [7:0] DIV_RST = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ****************************************************************
    // Timing counts: clock/4 prescale, then post divide by 16, 4 or 1
    // ****************************************************************
    localparam logic [1:0] PRE_LAST = 2'h3;
    localparam logic [3:0] POST_LOW = 4'hF;
    localparam logic [3:0] POST_MID = 4'h3;
    localparam logic [3:0] POST_NONE = 4'h0;

    typedef struct packed {
        logic [7:0] txsc;
        logic [7:0] rxsc;
        logic [7:0] ratec;
    } ctrl_s;

    typedef struct packed {
        logic tx_empty;
        logic rx_frame_err;
        logic rx_overrun;
        logic rx_bit9;
        logic rx_idle;
    } stat_s;

    typedef struct packed {
        logic [7:0] txsc;
        logic [7:0] rxsc;
        logic [7:0] ratec;
        logic [7:0] divh;
        logic [7:0] divl;
        logic aw_got;
        logic [7:0] aw_addr;
        logic w_got;
        logic [7:0] w_data;
        logic w_en;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [7:0] rdata;
        logic [1:0] pre;
        logic [15:0] tmr;
        logic [3:0] post;
        logic rx_s1;
        logic rx_s2;
        logic [2:0] smp;
        logic rx_level;
    } st_s;

    localparam st_s ST_RST = '{txsc: TXSC_RST, rxsc: RXSC_RST, ratec: RATE_RST,
        divh: DIV_RST, divl: DIV_RST, rx_s1: 1'b1, rx_s2: 1'b1, smp: 3'h7,
        rx_level: 1'b1, default: '0};

endpackage

//--- serial_partner.sv
// Far-side serial logic model: status levels and the receive line
`timescale 1ns/1ps
`default_nettype none
module serial_partner (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic rate_tick,
    input wire logic pin_drv,
    output var rate_pkg::stat_s stat,
    output logic rx_pin
);
    import rate_pkg::*;
    // Status moves only on bit ticks, so it stays frozen while the generator sleeps
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stat <= stat_s'(5'h15);
        end else if (rate_tick) begin
            stat <= stat_s'(stat + 5'h01);
        end
    end
    assign rx_pin = pin_drv;
endmodule
`default_nettype wire

//--- tb_rate_gen.sv
// Self-checking bench for the serial rate generator
`timescale 1ns/1ps
`default_nettype none
module tb_rate_gen;
    import rate_pkg::*;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, sleep_mode = 0, pin_drv = 1;
    logic [7:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [3:0] wstrb = '0;
    logic awready, wready, bvalid, arready, rvalid, rx_pin, rate_tick, rx_level;
    logic [1:0] bresp, rresp;
    stat_s stat;
    ctrl_s ctrl;
    int err_total = 0, samples_checked = 0;
    logic [31:0] seed = 36, pseed = 36;
    logic [5:0] ph = '1;
    logic [7:0] mdl [5] = '{TXSC_RST, RXSC_RST, RATE_RST, DIV_RST, DIV_RST};
    logic [7:0] wm [5] = '{TXSC_WMASK, RXSC_WMASK, RATE_WMASK, 8'hFF, 8'hFF};
    logic [7:0] tx_t [7] = '{8'h00, 8'h04, 8'h00, 8'h04, 8'h94, 8'h90, 8'h10};
    logic [7:0] rc_t [7] = '{8'h00, 8'h00, 8'h08, 8'h08, 8'h00, 8'h08, 8'h00};
    int pt [7] = '{16, 4, 4, 1, 1, 1, -1};

    rate_gen uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .sleep_mode(sleep_mode), .stat(stat),
        .rx_pin(rx_pin), .ctrl(ctrl), .rate_tick(rate_tick), .rx_level(rx_level));
    serial_partner far (.aclk(aclk), .aresetn(aresetn), .rate_tick(rate_tick),
        .pin_drv(pin_drv), .stat(stat), .rx_pin(rx_pin));

    initial begin
        forever #25 aclk = ~aclk;
    end

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    task automatic tally_and_finish;
        if (err_total == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic hang;
        err_total++;
        tally_and_finish;
    endtask

    // Status bits are live, so callers only use this while ticks are frozen
    function automatic logic [31:0] expv(input int k);
        logic [7:0] v;
        v = mdl[k] & wm[k];
        case (k)
            0: v[TX_EMPTY_BIT] = stat.tx_empty;
            1: v[2:0] = {stat.rx_frame_err, stat.rx_overrun, stat.rx_bit9};
            2: v[RATE_IDLE_BIT] = stat.rx_idle;
            default: ;
        endcase
        return {24'h0, v};
    endfunction

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
                      output logic [1:0] r);
        logic ad, wd, bv;
        ad = 0;
        wd = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= s;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        for (int i = 0; i < 99; i++) begin
            @(negedge aclk);
            ad |= awready;
            wd |= wready;
            bv = bvalid;
            r = bresp;
            @(posedge aclk);
            if (ad) awvalid <= 0;
            if (wd) wvalid <= 0;
            if (bv) begin
                bready <= 0;
                return;
            end
        end
        hang;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ag, rv;
        ag = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        for (int i = 0; i < 99; i++) begin
            @(negedge aclk);
            ag |= arready;
            rv = rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ag) arvalid <= 0;
            if (rv) begin
                rready <= 0;
                return;
            end
        end
        hang;
    endtask

    task automatic wait_tick(input int lim, output int n);
        n = -1;
        for (int i = 1; i <= lim; i++) begin
            @(negedge aclk);
            if (rate_tick === 1'b1) begin
                n = i;
                return;
            end
        end
    endtask

    // Receive line model: level follows the majority of three older samples
    always @(posedge aclk) begin
        ph <= {ph[4:0], rx_pin};
        if (aresetn) begin
            pseed = xs(pseed);
            pin_drv <= pseed[0];
        end
    end
    always @(negedge aclk) begin
        if (aresetn) chk(rx_level, (ph[3] & ph[4]) | (ph[3] & ph[5]) | (ph[4] & ph[5]));
    end

    initial begin
        logic [31:0] d;
        logic [1:0] r;
        int n, p, nv;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        sleep_mode <= 1;
        for (int k = 0; k < 5; k++) begin
            rd(8'(k * 4), d, r);
            chk(d, expv(k));
            seed = xs(seed);
            wr(8'(k * 4), seed[7:0], 4'h1, r);
            chk(r, RESP_OKAY);
            mdl[k] = seed[7:0];
            wr(8'(k * 4), ~seed[7:0], 4'h0, r);
            rd(8'(k * 4), d, r);
            chk(d, expv(k));
            chk(r, RESP_OKAY);
        end
        chk(32'(ctrl), {8'h0, mdl[0] & wm[0], mdl[1] & wm[1], mdl[2] & wm[2]});
        wr(8'h14, 8'hFF, 4'h1, r);
        chk(r, RESP_SLVERR);
        rd(8'h14, d, r);
        chk(d, 32'h0);
        chk(r, RESP_SLVERR);
        sleep_mode <= 0;
        for (int m = 0; m < 7; m++) begin
            seed = xs(seed);
            wr(OFS_TXSC, tx_t[m], 4'h1, r);
            wr(OFS_RATE, rc_t[m], 4'h1, r);
            wr(OFS_DIVH, {6'h0, seed[9:8]}, 4'h1, r);
            wr(OFS_DIVL, {4'h0, seed[3:0]}, 4'h1, r);
            nv = rc_t[m][RATE_WIDE_BIT] ? int'(seed[9:8]) * 256 + int'(seed[3:0])
                                        : int'(seed[3:0]);
            p = pt[m] < 0 ? -1 : 4 * (nv + 1) * pt[m];
            wait_tick(p > 0 ? p + 8 : 300, n);
            chk(n, p > 0 ? p - 1 : -1);
            if (p > 0) begin
                wait_tick(p + 8, n);
                chk(n, p);
            end
        end
        wr(OFS_TXSC, 8'h00, 4'h1, r);
        mdl[0] = 8'h00;
        wr(OFS_RATE, 8'h00, 4'h1, r);
        mdl[2] = 8'h00;
        // Clock change only once the receiver reports idle
        rd(OFS_RATE, d, r);
        for (int i = 0; i < 400 && !d[RATE_IDLE_BIT]; i++) begin
            rd(OFS_RATE, d, r);
        end
        chk(d[RATE_IDLE_BIT], 1'b1);
        sleep_mode <= 1;
        wait_tick(300, n);
        chk(n, -1);
        rd(OFS_RXSC, d, r);
        chk(d, expv(1));
        sleep_mode <= 0;
        wait_tick(2000, n);
        chk(n > 0, 1'b1);
        tally_and_finish;
    end
endmodule
`default_nettype wire
